// ---- design/saop_top.sv ----
/*
 * serial audio output port: control registers, strap capture, sample intake
 * and mute handling; the frame generator makes the bit clock, word select and serial data lines.
 * assumes a same-clock register port and sample source, and a converter
 * clock and strap pins that arrive asynchronously.
 */
`timescale 1ns/10ps
`default_nettype none

module saop_top #(
   parameter int SOFT_SHORT_CYC = saop_pkg::SOFT_SHORT_CYC,
   parameter int SOFT_LONG_CYC  = saop_pkg::SOFT_LONG_CYC
) (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        resetn_in,
   // register port
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [10:0] reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   output logic [31:0]      reg_rdata_out,
   // decoded sample source
   input  wire logic        sample_valid_in,
   input  wire logic [15:0] sample_left_in,
   input  wire logic [15:0] sample_right_in,
   output logic             sample_ready_out,
   // strap pins
   input  wire logic        strap_polarity_in,
   input  wire logic [2:0]  strap_ratio_in,
   input  wire logic        strap_lag_in,
   input  wire logic        strap_order_in,
   input  wire logic        strap_absent_in,
   input  wire logic        strap_edge_in,
   // converter link
   input  wire logic        dac_clk_in,
   output logic             sclk_out,
   output logic             word_select_line_out,
   output logic             serial_out_line_out,
   output logic             mute_ctrl_out,
   output logic [1:0]       rate_pins_out,
   output logic             rate_source_sel_out,
   output logic             pll_load_ctrl_out
);

   saop_frame_if fif ();

   // software state
   logic        sw_audio_disable_r, sw_audio_disable_nxt;
   logic [1:0]  sample_rate_sel_r, sample_rate_sel_nxt;
   logic        output_freeze_r, output_freeze_nxt;
   logic [1:0]  mute_select_r, mute_select_nxt;
   logic [31:0] pll_r, pll_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   // straps
   logic [7:0]  strap_s1_r, strap_s2_r;
   logic [7:0]  strap_r, strap_nxt;
   logic [1:0]  strap_wait_r, strap_wait_nxt;
   // link and samples
   logic [2:0]  dclk_r;
   logic [15:0] left_r, left_nxt;
   logic [15:0] right_r, right_nxt;
   logic [21:0] mute_cnt_r, mute_cnt_nxt;
   logic [1:0]  mute_prev_r;
   logic        mute_zero;
   logic        silent;
   logic        take;
   logic [31:0] ctrl_rd;

   // strap byte: 7 edge, 6 absent, 5 order, 4 lag, 3:1 ratio, 0 polarity
   wire logic       channel_polarity = strap_r[0];
   wire logic [2:0] clock_ratio_sel  = strap_r[3:1];
   wire logic       latch_window_sel = strap_r[4];
   wire logic       bit_order_sel    = strap_r[5];
   wire logic       converter_absent = strap_r[6];
   wire logic       clock_edge_sel   = strap_r[7];

   // ***********************************************************************
   // register port and strap capture
   // ***********************************************************************
   always_comb begin
      ctrl_rd = 32'h0000_0000;                                    // reserved read 0
      ctrl_rd[saop_pkg::DISABLE_BIT]                      = sw_audio_disable_r;
      ctrl_rd[saop_pkg::RATE_LSB +: 2]                    = sample_rate_sel_r;
      ctrl_rd[saop_pkg::FREEZE_BIT]                       = output_freeze_r;
      ctrl_rd[saop_pkg::MUTE_LSB +: 2]                    = mute_select_r;
      ctrl_rd[saop_pkg::POLARITY_BIT]                     = channel_polarity;
      ctrl_rd[saop_pkg::RATIO_LSB +: 3]                   = clock_ratio_sel;
      ctrl_rd[saop_pkg::LAG_BIT]                          = latch_window_sel;
      ctrl_rd[saop_pkg::ORDER_BIT]                        = bit_order_sel;
      ctrl_rd[saop_pkg::ABSENT_BIT]                       = converter_absent;
      ctrl_rd[saop_pkg::EDGE_BIT]                         = clock_edge_sel;
      sw_audio_disable_nxt = sw_audio_disable_r;
      sample_rate_sel_nxt  = sample_rate_sel_r;
      output_freeze_nxt    = output_freeze_r;
      mute_select_nxt      = mute_select_r;
      pll_nxt              = pll_r;
      rdata_nxt            = rdata_r;
      // only the writable fields take write data
      if (reg_wr_in && reg_addr_in == saop_pkg::OUT_CTRL_OFS) begin
         sw_audio_disable_nxt = reg_wdata_in[saop_pkg::DISABLE_BIT];
         sample_rate_sel_nxt  = reg_wdata_in[saop_pkg::RATE_LSB +: 2];
         output_freeze_nxt    = reg_wdata_in[saop_pkg::FREEZE_BIT];
         mute_select_nxt      = reg_wdata_in[saop_pkg::MUTE_LSB +: 2];
      end else if (reg_wr_in && reg_addr_in == saop_pkg::PLL_CTRL_OFS) begin
         pll_nxt = {14'h0000, reg_wdata_in[17:0]};
      end
      if (reg_rd_in && reg_addr_in == saop_pkg::OUT_CTRL_OFS) begin
         rdata_nxt = ctrl_rd;
      end else if (reg_rd_in && reg_addr_in == saop_pkg::PLL_CTRL_OFS) begin
         rdata_nxt = pll_r;
      end else if (reg_rd_in) begin
         rdata_nxt = 32'h0000_0000;                               // unmapped reads zero
      end
      // straps are caught once, after the pin synchroniser has filled
      strap_wait_nxt = strap_wait_r;
      strap_nxt      = strap_r;
      if (strap_wait_r != 2'(saop_pkg::STRAP_WAIT)) begin
         strap_wait_nxt = strap_wait_r + 2'd1;
         strap_nxt      = strap_s2_r;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sw_audio_disable_r <= saop_pkg::DISABLE_RST;
         sample_rate_sel_r  <= saop_pkg::RATE_RST;
         output_freeze_r    <= saop_pkg::FREEZE_RST;
         mute_select_r      <= saop_pkg::MUTE_RST;
         pll_r              <= saop_pkg::PLL_CTRL_RST;
         rdata_r            <= 32'h0000_0000;
         strap_s1_r         <= 8'h00;
         strap_s2_r         <= 8'h00;
         strap_r            <= 8'h00;
         strap_wait_r       <= 2'd0;
      end else begin
         sw_audio_disable_r <= sw_audio_disable_nxt;
         sample_rate_sel_r  <= sample_rate_sel_nxt;
         output_freeze_r    <= output_freeze_nxt;
         mute_select_r      <= mute_select_nxt;
         pll_r              <= pll_nxt;
         rdata_r            <= rdata_nxt;
         strap_s1_r         <= {strap_edge_in, strap_absent_in, strap_order_in,
                                strap_lag_in, strap_ratio_in, strap_polarity_in};
         strap_s2_r         <= strap_s1_r;
         strap_r            <= strap_nxt;
         strap_wait_r       <= strap_wait_nxt;
      end
   end

   // ***********************************************************************
   // mute timing and sample intake
   // ***********************************************************************
   always_comb begin
      // the converter ramps during a soft mute; zeros follow once it ends
      mute_cnt_nxt = mute_cnt_r;
      if (mute_select_r != mute_prev_r || mute_select_r == saop_pkg::MUTE_NONE) begin
         mute_cnt_nxt = 22'd0;
      end else if (mute_cnt_r != 22'h3fffff) begin
         mute_cnt_nxt = mute_cnt_r + 22'd1;
      end
      case (mute_select_r)
         saop_pkg::MUTE_HARD:  mute_zero = 1'b1;
         saop_pkg::MUTE_SOFT1: mute_zero = mute_cnt_r >= 22'(SOFT_SHORT_CYC);
         saop_pkg::MUTE_SOFT2: mute_zero = mute_cnt_r >= 22'(SOFT_LONG_CYC);
         default:              mute_zero = 1'b0;
      endcase
      silent = sw_audio_disable_r | converter_absent | mute_zero;
      // frozen: no pop, so nothing is dropped while held
      take   = fif.frame_start & ~silent & ~output_freeze_r & ~pll_r[saop_pkg::LOAD_BIT];
      left_nxt  = left_r;
      right_nxt = right_r;
      if (fif.frame_start) begin
         if (pll_r[saop_pkg::LOAD_BIT]) begin
            left_nxt  = {8'h00, pll_r[saop_pkg::LEFT_PLL_LSB +: 8]};
            right_nxt = {8'h00, pll_r[saop_pkg::RIGHT_PLL_LSB +: 8]};
         end else if (take && sample_valid_in) begin
            left_nxt  = sample_left_in;
            right_nxt = sample_right_in;
         end else begin
            left_nxt  = 16'h0000;                                 // zero samples
            right_nxt = 16'h0000;
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mute_cnt_r  <= 22'd0;
         mute_prev_r <= saop_pkg::MUTE_RST;
         left_r      <= 16'h0000;
         right_r     <= 16'h0000;
         dclk_r      <= 3'h0;
      end else begin
         mute_cnt_r  <= mute_cnt_nxt;
         mute_prev_r <= mute_select_r;
         left_r      <= left_nxt;
         right_r     <= right_nxt;
         dclk_r      <= {dclk_r[1:0], dac_clk_in};                // two-flop sync, then edge
      end
   end

   // ***********************************************************************
   // frame generator and converter lines
   // ***********************************************************************
   assign fif.tick       = dclk_r[1] & ~dclk_r[2];                // rising converter clock
   assign fif.ratio      = clock_ratio_sel;
   assign fif.lag        = latch_window_sel;
   assign fif.order      = bit_order_sel;
   assign fif.edge_sel   = clock_edge_sel;
   assign fif.polarity   = channel_polarity;
   assign fif.left_word  = left_r;
   assign fif.right_word = right_r;

   saop_framer u_framer (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .fr        (fif.framer)
   );

   assign sample_ready_out     = take;                            // pulses in the frame_start cycle, not gated by valid
   assign reg_rdata_out        = rdata_r;
   assign sclk_out             = fif.sclk;
   assign word_select_line_out = fif.ws;
   assign serial_out_line_out  = fif.serial_out_line;
   assign mute_ctrl_out        = mute_select_r != saop_pkg::MUTE_NONE;
   assign rate_pins_out        = sample_rate_sel_r;
   assign rate_source_sel_out  = pll_r[saop_pkg::SOURCE_BIT];
   assign pll_load_ctrl_out    = pll_r[saop_pkg::LOAD_BIT];

endmodule

`default_nettype wire

// ---- design/saop_pkg.sv ----
/*
 * constants shared by the serial audio output port: register offsets, field
 * positions, reset values and timing counts.
 * assumes a 200 MHz core clock and an 11-bit control space address.
 */
package saop_pkg;

   // ***********************************************************************
   // register map
   // ***********************************************************************
   localparam int          ADDR_W          = 11;
   localparam logic [10:0] OUT_CTRL_OFS    = 11'h300; // audio_output_control
   localparam logic [10:0] PLL_CTRL_OFS    = 11'h308; // converter_pll_control

   // ***********************************************************************
   // audio_output_control fields
   // ***********************************************************************
   localparam int DISABLE_BIT  = 0;
   localparam int RATE_LSB     = 2;
   localparam int FREEZE_BIT   = 7;
   localparam int MUTE_LSB     = 8;
   localparam int POLARITY_BIT = 11;
   localparam int RATIO_LSB    = 12;
   localparam int LAG_BIT      = 19;
   localparam int ORDER_BIT    = 20;
   localparam int ABSENT_BIT   = 21;
   localparam int EDGE_BIT     = 22;

   localparam logic       DISABLE_RST = 1'b1;
   localparam logic [1:0] RATE_RST    = 2'h1;
   localparam logic       FREEZE_RST  = 1'b0;
   localparam logic [1:0] MUTE_RST    = 2'h0;

   // ***********************************************************************
   // converter_pll_control fields
   // ***********************************************************************
   localparam int          LEFT_PLL_LSB  = 0;
   localparam int          RIGHT_PLL_LSB = 8;
   localparam int          SOURCE_BIT    = 16;
   localparam int          LOAD_BIT      = 17;
   localparam logic [31:0] PLL_CTRL_RST  = 32'h0000_0000;

   // ***********************************************************************
   // codes
   // ***********************************************************************
   localparam logic [1:0] MUTE_NONE  = 2'h0;
   localparam logic [1:0] MUTE_HARD  = 2'h1;
   localparam logic [1:0] MUTE_SOFT1 = 2'h2;
   localparam logic [1:0] MUTE_SOFT2 = 2'h3;
   localparam int         WINDOW_BITS = 16;

   // ***********************************************************************
   // timing
   // ***********************************************************************
   localparam int CLK_PERIOD_NS  = 5;
   localparam int SOFT_SHORT_MS  = 10;
   localparam int SOFT_LONG_MS   = 20;
   localparam int SOFT_SHORT_CYC = SOFT_SHORT_MS * 1000000 / CLK_PERIOD_NS;
   localparam int SOFT_LONG_CYC  = SOFT_LONG_MS * 1000000 / CLK_PERIOD_NS;
   localparam int STRAP_WAIT     = 3;   // cycles after release before straps are caught

endpackage

// ---- design/saop_frame_if.sv ----
/*
 * carrier between the port controller and its frame generator.
 * assumes both ends run on the same core clock.
 */
`timescale 1ns/10ps
`default_nettype none

interface saop_frame_if;
   logic        tick;        // one pulse per rising converter clock edge
   logic [2:0]  ratio;
   logic        lag;
   logic        order;
   logic        edge_sel;
   logic        polarity;
   logic [15:0] left_word;
   logic [15:0] right_word;
   logic        frame_start; // pulse: new left/right pair needed
   logic        sclk;
   logic        ws;
   logic        serial_out_line;

   modport ctrl   (output tick, ratio, lag, order, edge_sel, polarity, left_word,
                   right_word, input frame_start, sclk, ws, serial_out_line);
   modport framer (input tick, ratio, lag, order, edge_sel, polarity, left_word,
                   right_word, output frame_start, sclk, ws, serial_out_line);
endinterface

`default_nettype wire

// ---- design/saop_framer.sv ----
/*
 * frame generator: derives bit clock and word select from converter clock
 * ticks and shifts the held left/right words out.
 * assumes tick is a one-cycle pulse on the core clock.
 */
`timescale 1ns/10ps
`default_nettype none

module saop_framer (
   // clock and reset
   input  wire logic    clk_in,
   input  wire logic    resetn_in,
   // link to controller
   saop_frame_if.framer fr
);

   logic [2:0] sclk_cnt_r, sclk_cnt_nxt;
   logic [6:0] bit_cnt_r, bit_cnt_nxt;
   logic       phase_r, phase_nxt;      // 0 = left slot, 1 = right slot
   logic       start_r, start_nxt;
   logic       sclk_r, sclk_nxt;
   logic       ws_r, ws_nxt;
   logic       sd_r, sd_nxt;
   logic [2:0] div;                      // converter clocks per bit clock
   logic [6:0] bits;                     // bit clocks per word-select phase
   logic [6:0] win_lo;
   logic [6:0] k;
   logic [3:0] idx;
   logic [15:0] word;

   // ***********************************************************************
   // ratio decode and counters
   // ***********************************************************************
   always_comb begin
      case (fr.ratio)
         3'h0:    {div, bits} = {3'd2, 7'd64};
         3'h1:    {div, bits} = {3'd4, 7'd32};
         3'h2:    {div, bits} = {3'd2, 7'd96};
         3'h3:    {div, bits} = {3'd4, 7'd48};
         3'h4:    {div, bits} = {3'd6, 7'd32};
         3'h5:    {div, bits} = {3'd0, 7'd24};                  // 8 wraps to 0
         3'h6:    {div, bits} = {3'd4, 7'd64};
         default: {div, bits} = {3'd0, 7'd32};
      endcase
      sclk_cnt_nxt = sclk_cnt_r;
      bit_cnt_nxt  = bit_cnt_r;
      phase_nxt    = phase_r;
      start_nxt    = 1'b0;
      if (fr.tick) begin
         sclk_cnt_nxt = sclk_cnt_r + 3'd1;
         if (sclk_cnt_nxt == div) begin
            sclk_cnt_nxt = 3'd0;
            bit_cnt_nxt  = bit_cnt_r + 7'd1;
            if (bit_cnt_nxt == bits) begin
               bit_cnt_nxt = 7'd0;
               phase_nxt   = ~phase_r;
               start_nxt   = phase_r;                            // right done: new pair
            end
         end
      end
      // data changes at the start of a bit, the converter latches mid-bit
      win_lo   = fr.lag ? bits - 7'd16 : 7'd0;
      k        = bit_cnt_nxt - win_lo;
      idx      = fr.order ? 4'hf - k[3:0] : k[3:0];
      word     = phase_nxt ? fr.right_word : fr.left_word;
      sd_nxt   = (bit_cnt_nxt >= win_lo && k < 7'd16) ? word[idx] : 1'b0;
      // high half of bit period; inverted so the latch edge moves
      sclk_nxt = (sclk_cnt_nxt >= {1'b0, div[2:1]} + (div == 3'd0 ? 3'd4 : 3'd0)) ^
                 fr.edge_sel;
      ws_nxt   = phase_nxt ^ ~fr.polarity;
   end

   // ***********************************************************************
   // registers
   // ***********************************************************************
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         sclk_cnt_r <= 3'd0;
         bit_cnt_r  <= 7'd0;
         phase_r    <= 1'b0;
         start_r    <= 1'b0;
         sclk_r     <= 1'b0;
         ws_r       <= 1'b0;
         sd_r       <= 1'b0;
      end else begin
         sclk_cnt_r <= sclk_cnt_nxt;
         bit_cnt_r  <= bit_cnt_nxt;
         phase_r    <= phase_nxt;
         start_r    <= start_nxt;
         sclk_r     <= sclk_nxt;
         ws_r       <= ws_nxt;
         sd_r       <= sd_nxt;
      end
   end

   assign fr.frame_start = start_r;
   assign fr.sclk        = sclk_r;
   assign fr.ws          = ws_r;
   assign fr.serial_out_line       = sd_r;

endmodule

`default_nettype wire

// ---- dv/saop_dac_model.sv ----
/* stereo converter model: makes the converter clock and rebuilds the
   words it latches. assumes its format inputs match the port's straps. */
`timescale 1ns/10ps
`default_nettype none
module saop_dac_model (
   // converter clock out, serial lines in
   output logic        dac_clk_out,
   input  wire logic   sclk_in,
   input  wire logic   ws_in,
   input  wire logic   serial_out_line_in,
   // converter format setup
   input  wire logic   polarity_in,
   input  wire logic   lag_in,
   input  wire logic   order_in,
   input  wire logic   edge_in,
   // words seen in the last left and right phases
   output logic [15:0] left_out,
   output logic [15:0] right_out
);
   // ****************
   // converter side
   // ****************
   logic [15:0] sh = 16'h0;
   logic [15:0] first = 16'h0;
   int          n = 0;
   logic        ws_q = 1'b0;
   // free-running master clock, 125 ns
   initial begin
      dac_clk_out = 1'b0;
      forever #62.5 dac_clk_out = ~dac_clk_out;
   end
   // latch only on the strapped edge, data moves on the other one
   always @(sclk_in) begin
      if (sclk_in != edge_in) begin
         // first latch of a new phase restarts the bit count
         if (ws_in != ws_q) n = 0;
         ws_q = ws_in;
         sh = order_in ? {sh[14:0], serial_out_line_in} : {serial_out_line_in, sh[15:1]};
         n = n + 1;
         if (n == 16) first = sh;
      end
   end
   // a phase ends at each word-select change; keep the word it carried
   always @(ws_in) begin
      if (ws_in ^ polarity_in) right_out = lag_in ? sh : first;
      else left_out = lag_in ? sh : first;
   end
endmodule
`default_nettype wire

// ---- dv/saop_props.sv ----
/* assertions on the audio output port's pins.
   assumes bench holds straps steady for six edges after reset. */
`timescale 1ns/10ps
`default_nettype none
module saop_props (
   // clock, reset and register port
   input wire logic        clk_in,
   input wire logic        resetn_in,
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   input wire logic [10:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic [31:0] reg_rdata_out,
   // straps and converter side
   input wire logic        strap_polarity_in,
   input wire logic [2:0]  strap_ratio_in,
   input wire logic        strap_lag_in,
   input wire logic        strap_order_in,
   input wire logic        strap_absent_in,
   input wire logic        strap_edge_in,
   input wire logic        sample_ready_out,
   input wire logic        sclk_out,
   input wire logic        serial_out_line_out,
   input wire logic        mute_ctrl_out,
   input wire logic [1:0]  rate_pins_out,
   input wire logic        rate_source_sel_out,
   input wire logic        pll_load_ctrl_out
);
   // ****************
   // helper state
   // ****************
   logic [2:0]  cnt_r, cnt_nxt;
   logic [7:0]  cap_r, cap_nxt;
   logic [31:0] wd_r;
   logic        wo, wp, ro, ru;
   // decoded accesses
   assign wo = reg_wr_in && reg_addr_in == saop_pkg::OUT_CTRL_OFS;
   assign wp = reg_wr_in && reg_addr_in == saop_pkg::PLL_CTRL_OFS;
   assign ro = reg_rd_in && reg_addr_in == saop_pkg::OUT_CTRL_OFS;
   assign ru = reg_rd_in && !ro && reg_addr_in != saop_pkg::PLL_CTRL_OFS;
   // copy pins until settled, later than the port so no race at its catch
   always_comb begin
      cnt_nxt = (cnt_r == 3'h6) ? cnt_r : cnt_r + 3'h1;
      cap_nxt = (cnt_r == 3'h6) ? cap_r : {strap_edge_in, strap_absent_in, strap_order_in,
                                           strap_lag_in, strap_ratio_in, strap_polarity_in};
   end
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cnt_r <= 3'h0;
         cap_r <= 8'h00;
      end else begin
         cnt_r <= cnt_nxt;
         cap_r <= cap_nxt;
      end
   end
   // last write data, lined up with the cycle after a write
   always_ff @(posedge clk_in) begin
      wd_r <= reg_wdata_in;
   end
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   mute_line_a: assert property (wo |=> mute_ctrl_out == (wd_r[9:8] != 2'h0))
      else $error("mute line does not follow mute field");
   rate_pins_a: assert property (wo |=> rate_pins_out == wd_r[3:2])
      else $error("rate pins do not follow rate field");
   rate_source_a: assert property (wp |=> rate_source_sel_out == wd_r[16])
      else $error("rate source line does not follow its bit");
   pll_load_a: assert property (wp |=> pll_load_ctrl_out == wd_r[17])
      else $error("load line does not follow its bit");
   reserved_zero_a: assert property (ro |=> reg_rdata_out[31:23] == 9'h0 && !reg_rdata_out[10])
      else $error("reserved control bits read nonzero");
   unmapped_zero_a: assert property (ru |=> reg_rdata_out == 32'h0)
      else $error("unmapped read returned nonzero");
   strap_read_a: assert property (ro && cnt_r == 3'h6 |=>
      {reg_rdata_out[22:19], reg_rdata_out[14:11]} == cap_r)
      else $error("strap fields differ from pins at reset");
   data_edge_a: assert property (cnt_r == 3'h6 && $changed(serial_out_line_out)
      |-> sclk_out == cap_r[7]) else $error("data moved on the latching edge");
   sclk_hold_a: assert property ($rose(sclk_out) |=> $stable(sclk_out) [*8])
      else $error("bit clock half period too short");
   pop_gate_a: assert property (sample_ready_out |-> !pll_load_ctrl_out ##1 !sample_ready_out)
      else $error("sample taken during load or held");
   ready_c: cover property (sample_ready_out);
   load_c: cover property (wp ##1 pll_load_ctrl_out);
   mute_c: cover property (wo ##1 mute_ctrl_out);
endmodule
bind saop_top saop_props chk (
   .clk_in(clk_in), .resetn_in(resetn_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
   .strap_polarity_in(strap_polarity_in), .strap_ratio_in(strap_ratio_in),
   .strap_lag_in(strap_lag_in), .strap_order_in(strap_order_in),
   .strap_absent_in(strap_absent_in), .strap_edge_in(strap_edge_in),
   .sample_ready_out(sample_ready_out), .sclk_out(sclk_out),
   .serial_out_line_out(serial_out_line_out), .mute_ctrl_out(mute_ctrl_out),
   .rate_pins_out(rate_pins_out), .rate_source_sel_out(rate_source_sel_out),
   .pll_load_ctrl_out(pll_load_ctrl_out)
);
`default_nettype wire

// ---- dv/tb_serial_audio_output_port.sv ----
/* self-checking bench for the audio output port.
   assumes the converter model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module tb_serial_audio_output_port;
   // ****************
   // stimulus and wiring
   // ****************
   localparam logic [10:0] OC = saop_pkg::OUT_CTRL_OFS;
   localparam logic [10:0] PC = saop_pkg::PLL_CTRL_OFS;
   logic        clk_in = 1'b0;
   logic        resetn_in = 1'b0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [10:0] addr = 11'h0;
   logic [31:0] wd = 32'h0;
   logic [7:0]  st = 8'h00;
   logic [31:0] rdata;
   logic [15:0] lw, rw;
   logic [1:0]  rate;
   logic        dclk, sclk, ws, serial_out_line, mute, src, load, ready;
   int          n_fail = 0;
   int          checked = 0;
   int          pops = 0;
   // 200 MHz core clock
   always #2.5 clk_in = ~clk_in;
   // short soft-mute counts keep the run brief
   saop_top #(.SOFT_SHORT_CYC(20), .SOFT_LONG_CYC(40)) uut (
      .clk_in(clk_in), .resetn_in(resetn_in), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_addr_in(addr), .reg_wdata_in(wd), .reg_rdata_out(rdata),
      .sample_valid_in(1'b1), .sample_left_in(16'ha5c3), .sample_right_in(16'h1234),
      .sample_ready_out(ready), .strap_polarity_in(st[0]), .strap_ratio_in(st[3:1]),
      .strap_lag_in(st[4]), .strap_order_in(st[5]), .strap_absent_in(st[6]),
      .strap_edge_in(st[7]), .dac_clk_in(dclk), .sclk_out(sclk),
      .word_select_line_out(ws), .serial_out_line_out(serial_out_line), .mute_ctrl_out(mute),
      .rate_pins_out(rate), .rate_source_sel_out(src), .pll_load_ctrl_out(load));
   saop_dac_model dac (.dac_clk_out(dclk), .sclk_in(sclk), .ws_in(ws), .serial_out_line_in(serial_out_line),
      .polarity_in(st[0]), .lag_in(st[4]), .order_in(st[5]), .edge_in(st[7]),
      .left_out(lw), .right_out(rw));
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr32(input logic [10:0] a, input logic [31:0] d);
      @(posedge clk_in);
      wr <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge clk_in);
      wr <= 1'b0;
   endtask
   task automatic rdc(input logic [10:0] a, input logic [31:0] e, input string nm);
      @(posedge clk_in);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk_in);
      rd <= 1'b0;
      @(posedge clk_in);
      #1 chk(nm, e, rdata);
   endtask
   // straps stay put while the port catches them
   task automatic do_reset(input logic [7:0] s);
      @(posedge clk_in);
      resetn_in <= 1'b0;
      st <= s;
      repeat (6) @(posedge clk_in);
      resetn_in <= 1'b1;
      repeat (6) @(posedge clk_in);
   endtask
   // count word-select rises, bounded so a dead link cannot hang the run
   task automatic frames(input int k);
      int t;
      int n;
      logic p;
      t = 0;
      n = 0;
      p = ws;
      pops = 0;
      while (n < k) begin
         @(negedge clk_in);
         if (ws && !p) n++;
         if (ready) pops++;
         p = ws;
         t++;
         if (t > 40000) begin
            n_fail++;
            $display("wrong value frame wait expected word select edges seen none");
            report_and_stop;
         end
      end
   endtask
   initial begin
      do_reset(8'h00);
      rdc(OC, 32'h5, "ctrl reset");
      rdc(PC, 32'h0, "pll reset");
      wr32(OC, 32'hffff_ffff);
      wr32(PC, 32'hffff_ffff);
      rdc(OC, 32'h38d, "ctrl ones");
      rdc(PC, 32'h3_ffff, "pll ones");
      chk("pll lines", 32'h3, {30'h0, load, src});
      rdc(11'h304, 32'h0, "unmapped");
      wr32(11'h200, 32'h0);
      rdc(OC, 32'h38d, "ctrl kept");
      for (int i = 0; i < 4; i++) begin
         wr32(OC, {22'h0, i[1:0], 4'h0, i[1:0], 2'h1});
         @(posedge clk_in);
         #1 chk("mute rate", {29'h0, i[1:0] != 2'h0, i[1:0]}, {29'h0, mute, rate});
      end
      wr32(PC, 32'h0);
      wr32(OC, 32'h0);
      frames(2);
      chk("words", 32'ha5c3_1234, {lw, rw});
      wr32(PC, 32'h2_5a3c);
      frames(2);
      chk("pll words", 32'h003c_005a, {lw, rw});
      wr32(PC, 32'h0);
      wr32(OC, 32'h100);
      frames(2);
      chk("muted", 32'h0, {lw, rw});
      wr32(OC, 32'h200);
      frames(3);
      chk("soft muted", 32'h0, {lw, rw});
      wr32(OC, 32'h80);
      frames(2);
      chk("frozen", 32'h0, {lw, rw});
      chk("frozen pops", 32'h0, pops);
      do_reset(8'hb3);
      wr32(OC, 32'h0);
      frames(3);
      chk("words b", 32'ha5c3_1234, {lw, rw});
      @(posedge clk_in) st <= 8'h00;
      rdc(OC, 32'h0058_1800, "straps kept");
      do_reset(8'h40);
      rdc(OC, 32'h0020_0005, "absent");
      report_and_stop;
   end
endmodule
`default_nettype wire
